// ### dram_pkg.sv
// Shared constants, types and helpers for the DRAM command and address pin link.
package dram_pkg;
  localparam int unsigned ROW_W  = 14;
  localparam int unsigned COL_W  = 10;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned BANKS  = 8;
  localparam int unsigned MR_CNT = 4;
  localparam int unsigned DQ_W   = 8;

  localparam int unsigned AP_BIT       = 10;
  localparam int unsigned BC_BIT       = 12;
  localparam int unsigned MR1_TDQS_BIT = 11;
  localparam int unsigned MR1_RTT_B0   = 2;
  localparam int unsigned MR1_RTT_B1   = 6;
  localparam int unsigned MR1_RTT_B2   = 9;
  localparam int unsigned MR2_RTTWR_LO = 9;
  localparam int unsigned MR2_RTTWR_HI = 10;
  localparam int unsigned MR0_BL_HI    = 1;

  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_CHOP4  = 2'h2;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;

  // Edges counted from the command edge to the first data beat at the controller.
  localparam logic [3:0] WR_LEAD = 4'h2;
  localparam logic [3:0] RD_LEAD = 4'h5;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_WDATA0 = 8'h10;
  localparam logic [7:0] REG_WDATA1 = 8'h14;
  localparam logic [7:0] REG_WMASK  = 8'h18;
  localparam logic [7:0] REG_RDATA0 = 8'h1C;
  localparam logic [7:0] REG_RDATA1 = 8'h20;

  localparam int unsigned CTRL_CKE   = 0;
  localparam int unsigned CTRL_ODT   = 1;
  localparam int unsigned CTRL_RST   = 2;
  localparam int unsigned CTRL_BL_LO = 3;
  localparam int unsigned CTRL_W     = 5;
  localparam int unsigned CMD_BANK_LO = 3;

  // Codes are the row, column and write strobe levels of the command.
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_ZQ  = 3'h6,
    CMD_NOP = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_PD_PRE = 2'h1,
    PWR_PD_ACT = 2'h2,
    PWR_SELF   = 2'h3
  } pwr_t;

  function automatic logic [3:0] burst_beats(input logic [1:0] bl_mode, input logic chop_n);
    case (bl_mode)
      BL_OTF:   burst_beats = chop_n ? BEATS_FULL : BEATS_CHOP;
      BL_CHOP4: burst_beats = BEATS_CHOP;
      default:  burst_beats = BEATS_FULL;
    endcase
  endfunction
endpackage

// ### dram_link_if.sv
// Pin-level link between the memory controller and the DRAM device.
`timescale 1ns/1ps
interface dram_link_if;
  logic                       cke;
  logic                       cs_n;
  logic                       row_strobe_n;
  logic                       col_strobe_n;
  logic                       wr_enable_n;
  logic [dram_pkg::BANK_W-1:0] bank_select;
  logic [dram_pkg::ROW_W-1:0]  address_bus;
  logic                       termination_ctl;
  logic                       write_mask;
  logic                       reset_n;
  logic [dram_pkg::DQ_W-1:0]   dq_c;
  logic                       dq_c_oe;
  logic [dram_pkg::DQ_W-1:0]   dq_d;
  logic                       dq_d_oe;
  logic [dram_pkg::DQ_W-1:0]   dq;

  // Undriven data lines read as all ones, like a terminated bus at rest.
  assign dq = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : 8'hFF);

  modport ctl (
    output cke, cs_n, row_strobe_n, col_strobe_n, wr_enable_n, bank_select, address_bus,
    output termination_ctl, write_mask, reset_n, dq_c, dq_c_oe,
    input  dq
  );
  modport dev (
    input  cke, cs_n, row_strobe_n, col_strobe_n, wr_enable_n, bank_select, address_bus,
    input  termination_ctl, write_mask, reset_n, dq,
    output dq_d, dq_d_oe
  );
endinterface

// ### dram_dev_end.sv
// Device end: command, address, power and termination pin logic of the DRAM.
`timescale 1ns/1ps
module dram_dev_end (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  dram_link_if.dev                           link,
  input  wire logic [dram_pkg::DQ_W-1:0]     rd_data,
  output logic                               evt_valid_q,
  output dram_pkg::cmd_t                     evt_cmd_q,
  output logic [dram_pkg::BANK_W-1:0]        evt_bank_q,
  output logic [dram_pkg::ROW_W-1:0]         evt_addr_q,
  output logic                               wr_valid_q,
  output logic [dram_pkg::DQ_W-1:0]          wr_data_q,
  output logic                               rd_req_q,
  output logic [dram_pkg::BANK_W-1:0]        beat_bank_q,
  output logic [dram_pkg::ROW_W-1:0]         beat_row_q,
  output logic [dram_pkg::COL_W-1:0]         beat_col_q,
  output logic [dram_pkg::BANKS-1:0]         bank_open_q,
  output dram_pkg::pwr_t                     power_state_q,
  output logic                               term_dq_q,
  output logic                               term_tdqs_q
);
  logic                        cke_q;
  logic                        cke_prev_q;
  logic                        cs_n_q;
  logic                        odt_q;
  logic [2:0]                  rcw_q;
  logic [dram_pkg::BANK_W-1:0] bsel_q;
  logic [dram_pkg::ROW_W-1:0]  addr_q;
  logic [dram_pkg::ROW_W-1:0]  mr_q [0:dram_pkg::MR_CNT-1];
  logic [dram_pkg::ROW_W-1:0]  row_q [0:dram_pkg::BANKS-1];
  logic [3:0]                  left_q;
  logic [2:0]                  idx_q;
  logic                        bwr_q;
  logic                        bap_q;
  logic [dram_pkg::BANK_W-1:0] bbank_q;
  logic [dram_pkg::COL_W-1:0]  bcol_q;
  dram_pkg::pwr_t              pwr_d;

  // The reset pin clears everything, mode registers and open rows included.
  wire logic dev_rst_b = rst_b & link.reset_n;

  wire logic           cmd_buf_en = (power_state_q == dram_pkg::PWR_NORMAL);
  wire logic           odt_buf_en = (power_state_q != dram_pkg::PWR_SELF);
  wire dram_pkg::cmd_t cmd        = dram_pkg::cmd_t'(rcw_q);
  wire logic           selected   = !cs_n_q && cke_q && cke_prev_q;
  wire logic           hit        = selected && (cmd != dram_pkg::CMD_NOP);
  wire logic           hit_act    = hit && (cmd == dram_pkg::CMD_ACT);
  wire logic           hit_pre    = hit && (cmd == dram_pkg::CMD_PRE);
  wire logic           hit_mrs    = hit && (cmd == dram_pkg::CMD_MRS) && !bsel_q[dram_pkg::BANK_W-1];
  wire logic           hit_rdwr   = hit && ((cmd == dram_pkg::CMD_RD) || (cmd == dram_pkg::CMD_WR));
  wire logic           all_idle   = (bank_open_q == '0);
  wire logic           sr_entry   = cmd_buf_en && !cs_n_q && cke_prev_q && !cke_q &&
                                    (cmd == dram_pkg::CMD_REF) && all_idle;
  wire logic [1:0]     bl_mode    = mr_q[0][dram_pkg::MR0_BL_HI:0];
  wire logic           tdqs_en    = mr_q[1][dram_pkg::MR1_TDQS_BIT];
  wire logic           odt_prog   = mr_q[1][dram_pkg::MR1_RTT_B0] | mr_q[1][dram_pkg::MR1_RTT_B1] |
                                    mr_q[1][dram_pkg::MR1_RTT_B2] | mr_q[2][dram_pkg::MR2_RTTWR_LO] |
                                    mr_q[2][dram_pkg::MR2_RTTWR_HI];
  wire logic           b_active   = (left_q != 4'h0);
  wire logic           b_last     = (left_q == 4'h1);
  wire logic           masked     = link.write_mask && !tdqs_en;
  wire logic [2:0]     col_lo     = bcol_q[2:0] + idx_q;
  wire logic [3:0]     beats      = dram_pkg::burst_beats(bl_mode, addr_q[dram_pkg::BC_BIT]);

  // ****************************************************************
  // Pin capture
  // ****************************************************************
  // Command pins are held at deselect while their buffers are off, so stale levels never decode.
  always_ff @(posedge clk or negedge dev_rst_b) begin
    if (!dev_rst_b) begin
      cke_q      <= 1'b0;
      cke_prev_q <= 1'b0;
      cs_n_q     <= 1'b1;
      rcw_q      <= dram_pkg::CMD_NOP;
      bsel_q     <= '0;
      addr_q     <= '0;
      odt_q      <= 1'b0;
    end else if (ce) begin
      cke_q      <= link.cke;
      cke_prev_q <= cke_q;
      cs_n_q     <= cmd_buf_en ? link.cs_n : 1'b1;
      odt_q      <= odt_buf_en & link.termination_ctl;
      if (cmd_buf_en) begin
        rcw_q  <= {link.row_strobe_n, link.col_strobe_n, link.wr_enable_n};
        bsel_q <= link.bank_select;
        addr_q <= link.address_bus;
      end
    end
  end

  // ****************************************************************
  // Power state
  // ****************************************************************
  always_comb begin
    pwr_d = power_state_q;
    case (power_state_q)
      dram_pkg::PWR_NORMAL: begin
        if (sr_entry) begin
          pwr_d = dram_pkg::PWR_SELF;
        end else if (!cke_q) begin
          pwr_d = all_idle ? dram_pkg::PWR_PD_PRE : dram_pkg::PWR_PD_ACT;
        end
      end
      dram_pkg::PWR_PD_PRE,
      dram_pkg::PWR_PD_ACT: begin
        if (cke_q) begin
          pwr_d = dram_pkg::PWR_NORMAL;
        end
      end
      dram_pkg::PWR_SELF: begin
        // The raw pin is looked at here, so the exit needs no captured clock-gate level.
        if (link.cke) begin
          pwr_d = dram_pkg::PWR_NORMAL;
        end
      end
      default: pwr_d = dram_pkg::PWR_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge dev_rst_b) begin
    if (!dev_rst_b) begin
      power_state_q <= dram_pkg::PWR_NORMAL;
    end else if (ce) begin
      power_state_q <= pwr_d;
    end
  end

  // ****************************************************************
  // Mode registers and banks
  // ****************************************************************
  always_ff @(posedge clk or negedge dev_rst_b) begin
    if (!dev_rst_b) begin
      for (int m = 0; m < dram_pkg::MR_CNT; m++) begin
        mr_q[m] <= '0;
      end
    end else if (ce && hit_mrs) begin
      mr_q[bsel_q[1:0]] <= addr_q;
    end
  end

  for (genvar b = 0; b < dram_pkg::BANKS; b++) begin : g_bank
    wire logic sel_b   = (bsel_q == dram_pkg::BANK_W'(b));
    wire logic close_b = (hit_pre && (addr_q[dram_pkg::AP_BIT] || sel_b)) ||
                         (b_last && bap_q && (bbank_q == dram_pkg::BANK_W'(b)));
    always_ff @(posedge clk or negedge dev_rst_b) begin
      if (!dev_rst_b) begin
        bank_open_q[b] <= 1'b0;
        row_q[b]       <= '0;
      end else if (ce) begin
        if (hit_act && sel_b) begin
          bank_open_q[b] <= 1'b1;
          row_q[b]       <= addr_q;
        end else if (close_b) begin
          bank_open_q[b] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Burst sequencing
  // ****************************************************************
  // A new access command restarts the burst; the controller is expected to space them.
  always_ff @(posedge clk or negedge dev_rst_b) begin
    if (!dev_rst_b) begin
      left_q  <= 4'h0;
      idx_q   <= 3'h0;
      bwr_q   <= 1'b0;
      bap_q   <= 1'b0;
      bbank_q <= '0;
      bcol_q  <= '0;
    end else if (ce) begin
      if (hit_rdwr) begin
        left_q  <= beats;
        idx_q   <= 3'h0;
        bwr_q   <= (cmd == dram_pkg::CMD_WR);
        bap_q   <= addr_q[dram_pkg::AP_BIT];
        bbank_q <= bsel_q;
        bcol_q  <= addr_q[dram_pkg::COL_W-1:0];
      end else if (b_active) begin
        left_q <= left_q - 4'h1;
        idx_q  <= idx_q + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Beats, events and data pins
  // ****************************************************************
  always_ff @(posedge clk or negedge dev_rst_b) begin
    if (!dev_rst_b) begin
      evt_valid_q <= 1'b0;
      evt_cmd_q   <= dram_pkg::CMD_NOP;
      evt_bank_q  <= '0;
      evt_addr_q  <= '0;
      wr_valid_q  <= 1'b0;
      wr_data_q   <= '0;
      rd_req_q    <= 1'b0;
      beat_bank_q <= '0;
      beat_row_q  <= '0;
      beat_col_q  <= '0;
      link.dq_d    <= '0;
      link.dq_d_oe <= 1'b0;
    end else if (ce) begin
      evt_valid_q <= hit;
      if (hit) begin
        evt_cmd_q  <= cmd;
        evt_bank_q <= bsel_q;
        evt_addr_q <= addr_q;
      end
      wr_valid_q <= b_active && bwr_q && !masked;
      rd_req_q   <= b_active && !bwr_q;
      if (b_active) begin
        wr_data_q   <= link.dq;
        beat_bank_q <= bbank_q;
        beat_row_q  <= row_q[bbank_q];
        beat_col_q  <= {bcol_q[dram_pkg::COL_W-1:3], col_lo};
      end
      // Output drivers follow the power state, so nothing is driven from the edge after power-down or self-refresh is entered.
      link.dq_d_oe <= rd_req_q && cmd_buf_en;
      if (rd_req_q) begin
        link.dq_d <= rd_data;
      end
    end
  end

  // ****************************************************************
  // Termination
  // ****************************************************************
  always_ff @(posedge clk or negedge dev_rst_b) begin
    if (!dev_rst_b) begin
      term_dq_q   <= 1'b0;
      term_tdqs_q <= 1'b0;
    end else if (ce) begin
      term_dq_q   <= odt_q && odt_prog && odt_buf_en;
      term_tdqs_q <= odt_q && odt_prog && odt_buf_en && tdqs_en;
    end
  end
endmodule

// ### dram_ctl_end.sv
// Controller end: register port that drives DRAM commands, bursts and control pins.
`timescale 1ns/1ps
module dram_ctl_end (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  dram_link_if.ctl         link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_q
);
  logic [dram_pkg::CTRL_W-1:0] ctrl_q;
  logic [dram_pkg::ROW_W-1:0]  addr_q;
  logic [63:0]                 wdata_q;
  logic [7:0]                  wmask_q;
  logic [63:0]                 rdata_q;
  logic [3:0]                  cnt_q;
  logic [3:0]                  len_q;
  logic                        cur_wr_q;

  wire dram_pkg::cmd_t code    = dram_pkg::cmd_t'(reg_wdata[2:0]);
  wire logic           busy    = (cnt_q != 4'h0);
  wire logic           cmd_go  = reg_wr && (reg_addr == dram_pkg::REG_CMD) && !busy;
  wire logic           burst   = cmd_go && ((code == dram_pkg::CMD_WR) || (code == dram_pkg::CMD_RD));
  wire logic [3:0]     lead    = cur_wr_q ? dram_pkg::WR_LEAD : dram_pkg::RD_LEAD;
  wire logic [3:0]     beat    = cnt_q - lead;
  wire logic           in_data = busy && (cnt_q >= lead) && (beat < len_q);
  wire logic [3:0]     beats   = dram_pkg::burst_beats(ctrl_q[dram_pkg::CTRL_BL_LO +: 2],
                                                       addr_q[dram_pkg::BC_BIT]);

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q      <= '0;
      addr_q      <= '0;
      wdata_q     <= '0;
      wmask_q     <= '0;
      reg_rdata_q <= '0;
    end else if (ce) begin
      if (reg_wr) begin
        case (reg_addr)
          dram_pkg::REG_CTRL:   ctrl_q <= reg_wdata[dram_pkg::CTRL_W-1:0];
          dram_pkg::REG_ADDR:   addr_q <= reg_wdata[dram_pkg::ROW_W-1:0];
          dram_pkg::REG_WDATA0: wdata_q[31:0] <= reg_wdata;
          dram_pkg::REG_WDATA1: wdata_q[63:32] <= reg_wdata;
          dram_pkg::REG_WMASK:  wmask_q <= reg_wdata[7:0];
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          dram_pkg::REG_CTRL:   reg_rdata_q <= {27'h0, ctrl_q};
          dram_pkg::REG_ADDR:   reg_rdata_q <= {18'h0, addr_q};
          dram_pkg::REG_STATUS: reg_rdata_q <= {31'h0, busy};
          dram_pkg::REG_WDATA0: reg_rdata_q <= wdata_q[31:0];
          dram_pkg::REG_WDATA1: reg_rdata_q <= wdata_q[63:32];
          dram_pkg::REG_WMASK:  reg_rdata_q <= {24'h0, wmask_q};
          dram_pkg::REG_RDATA0: reg_rdata_q <= rdata_q[31:0];
          dram_pkg::REG_RDATA1: reg_rdata_q <= rdata_q[63:32];
          default:              reg_rdata_q <= 32'h0;
        endcase
      end else begin
        reg_rdata_q <= 32'h0;
      end
    end
  end

  // ****************************************************************
  // Command pins and burst timing
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= 4'h0;
      len_q    <= 4'h0;
      cur_wr_q <= 1'b0;
      link.cs_n            <= 1'b1;
      link.row_strobe_n    <= 1'b1;
      link.col_strobe_n    <= 1'b1;
      link.wr_enable_n     <= 1'b1;
      link.bank_select     <= '0;
      link.address_bus     <= '0;
      link.cke             <= 1'b0;
      link.termination_ctl <= 1'b0;
      link.reset_n         <= 1'b0;
    end else if (ce) begin
      // Only one command is in flight; a command written while busy is dropped.
      link.cs_n <= !cmd_go;
      {link.row_strobe_n, link.col_strobe_n, link.wr_enable_n} <= cmd_go ? code : dram_pkg::CMD_NOP;
      if (cmd_go) begin
        link.bank_select <= reg_wdata[dram_pkg::CMD_BANK_LO +: dram_pkg::BANK_W];
        link.address_bus <= addr_q;
      end
      link.cke             <= ctrl_q[dram_pkg::CTRL_CKE] || busy || burst;
      link.termination_ctl <= ctrl_q[dram_pkg::CTRL_ODT];
      link.reset_n         <= ctrl_q[dram_pkg::CTRL_RST];
      if (burst) begin
        cnt_q    <= 4'h1;
        len_q    <= beats;
        cur_wr_q <= (code == dram_pkg::CMD_WR);
      end else if (busy) begin
        cnt_q <= (cnt_q == lead + len_q) ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Data beats
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.dq_c       <= '0;
      link.dq_c_oe    <= 1'b0;
      link.write_mask <= 1'b0;
      rdata_q         <= '0;
    end else if (ce) begin
      link.dq_c_oe    <= in_data && cur_wr_q;
      link.write_mask <= in_data && cur_wr_q && wmask_q[beat[2:0]];
      if (in_data && cur_wr_q) begin
        link.dq_c <= wdata_q[beat[2:0]*8 +: 8];
      end
      if (in_data && !cur_wr_q) begin
        rdata_q[beat[2:0]*8 +: 8] <= link.dq;
      end
    end
  end
endmodule

// ### dram_link_asserts.sv
// Concurrent checks on the pin link between the controller end and the device end.
`timescale 1ns/1ps
module dram_link_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic wr_enable_n,
  input wire logic reset_n,
  input wire logic dq_c_oe,
  input wire logic dq_d_oe
);
  wire logic [2:0] code;
  wire logic       wr_cmd;
  wire logic       rd_cmd;
  assign code   = {row_strobe_n, col_strobe_n, wr_enable_n};
  assign wr_cmd = !cs_n && code == 3'h4;
  // A read only answers once the device is out of reset.
  assign rd_cmd = !cs_n && code == 3'h5 && reset_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_cmd_pulse; !cs_n |=> cs_n; endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command held over one cycle");
  property p_idle_code; cs_n |-> code == 3'h7; endproperty
  a_idle_code: assert property (p_idle_code) else $error("strobes not idle while deselected");
  // A refresh with the gate low is the self-refresh entry, so only that command may see it low.
  property p_cke_cmd; (!cs_n && code != 3'h1) |-> cke; endproperty
  a_cke_cmd: assert property (p_cke_cmd) else $error("clock gate low in command cycle");
  property p_cke_burst; (dq_c_oe || dq_d_oe) |-> cke; endproperty
  a_cke_burst: assert property (p_cke_burst) else $error("clock gate low during burst");
  property p_wr_lead; wr_cmd |-> ##2 dq_c_oe [*4]; endproperty
  a_wr_lead: assert property (p_wr_lead) else $error("write data late or short");
  property p_rd_lead; rd_cmd |-> ##4 dq_d_oe [*4]; endproperty
  a_rd_lead: assert property (p_rd_lead) else $error("read data late or short");
  property p_wr_cause; $rose(dq_c_oe) |-> $past(wr_cmd, 2); endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write data without write command");
  property p_burst_len; $fell(dq_c_oe) |-> $past(dq_c_oe, 4); endproperty
  a_burst_len: assert property (p_burst_len) else $error("write burst under four beats");
  property p_dev_reset; !reset_n |-> !dq_d_oe; endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("device drives data in reset");
  c_wr: cover property (wr_cmd);
  c_rd: cover property (rd_cmd);
  c_mrs: cover property (!cs_n && code == 3'h0);
endmodule

// ### tb_sdram_cmd_addr_pin_logic.sv
// Self-checking bench: controller end and device end joined over the pin link.
`timescale 1ns/1ps
module tb_sdram_cmd_addr_pin_logic;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 ce = 1'b1;
  logic [31:0]          reg_rdata_q;
  logic [7:0]           rd_mem [8];
  logic [7:0]           rd_data;
  logic                 wr_valid_q, rd_req_q, term_dq_q, term_tdqs_q;
  dram_pkg::cmd_t       evt_cmd_q;
  logic [2:0]           evt_bank_q;
  logic [13:0]          evt_addr_q;
  logic [7:0]           wr_data_q, bank_open_q, wq[$];
  logic [9:0]           beat_col_q;
  dram_pkg::pwr_t       power_state_q;
  int                   failures, n_tests, nrd, cyc;
  always #4 clk = ~clk;
  // Read bytes depend on the beat column, so a wrong wrap order shows in the data.
  assign rd_data = rd_mem[beat_col_q[2:0]];
  dram_link_if link_if ();
  dram_ctl_end i_dram_ctl_end (.clk(clk), .rst_b(rst_b), .ce(ce), .link(link_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  dram_dev_end i_dram_dev_end (.clk(clk), .rst_b(rst_b), .ce(ce), .link(link_if), .rd_data(rd_data),
    .evt_valid_q(), .evt_cmd_q(evt_cmd_q), .evt_bank_q(evt_bank_q), .evt_addr_q(evt_addr_q),
    .wr_valid_q(wr_valid_q), .wr_data_q(wr_data_q), .rd_req_q(rd_req_q), .beat_bank_q(), .beat_row_q(),
    .beat_col_q(beat_col_q), .bank_open_q(bank_open_q), .power_state_q(power_state_q),
    .term_dq_q(term_dq_q), .term_tdqs_q(term_tdqs_q));
  dram_link_asserts i_dram_link_asserts (.clk(clk), .rst_b(rst_b), .cke(link_if.cke), .cs_n(link_if.cs_n),
    .row_strobe_n(link_if.row_strobe_n), .col_strobe_n(link_if.col_strobe_n), .wr_enable_n(link_if.wr_enable_n),
    .reset_n(link_if.reset_n), .dq_c_oe(link_if.dq_c_oe), .dq_d_oe(link_if.dq_d_oe));
  always @(posedge clk) begin
    cyc++;
    if (wr_valid_q === 1'b1) wq.push_back(wr_data_q);
    if (rd_req_q === 1'b1) nrd++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic cmd(input dram_pkg::cmd_t c, input logic [2:0] b, input logic [13:0] a);
    logic [31:0] s;
    wr(dram_pkg::REG_ADDR, {18'h0, a});
    wr(dram_pkg::REG_CMD, {26'h0, b, c});
    s = 32'h1;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++) rd(dram_pkg::REG_STATUS, s);
    chk("busy", 32'h0, s);
    repeat (3) @(posedge clk);
  endtask
  task automatic pwr(input logic [31:0] ctrl, input dram_pkg::pwr_t e);
    wr(dram_pkg::REG_CTRL, ctrl);
    repeat (4) @(posedge clk);
    chk("power", {30'h0, e}, {30'h0, power_state_q});
  endtask
  initial begin
    logic [31:0] v, w1, m;
    logic [63:0] d, e;
    logic [2:0]  b;
    logic [13:0] col;
    logic [7:0]  eq[$];
    void'($urandom(32'h52CC));
    for (int i = 0; i < 8; i++) rd_mem[i] = 8'($urandom());
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h40, v);
    chk("unmapped", 32'h0, v);
    wr(dram_pkg::REG_CTRL, 32'h5);
    b = 3'($urandom());
    v = $urandom();
    cmd(dram_pkg::CMD_ACT, b, v[13:0]);
    chk("evt_cmd", {29'h0, dram_pkg::CMD_ACT}, {29'h0, evt_cmd_q});
    chk("evt_bank", {29'h0, b}, {29'h0, evt_bank_q});
    chk("evt_addr", {18'h0, v[13:0]}, {18'h0, evt_addr_q});
    chk("bank_open", 32'h1 << b, {24'h0, bank_open_q});
    $display("activate test done");
    d = {$urandom(), $urandom()};
    m = $urandom();
    wr(dram_pkg::REG_WDATA0, d[31:0]);
    wr(dram_pkg::REG_WDATA1, d[63:32]);
    wr(dram_pkg::REG_WMASK, {24'h0, m[7:0]});
    for (int k = 0; k < 8; k++) if (!m[k]) eq.push_back(d[8*k +: 8]);
    wq = {};
    col = 14'h1000 | 14'($urandom() & 32'h3FF);
    cmd(dram_pkg::CMD_WR, b, col);
    chk("wr_beats", eq.size(), wq.size());
    foreach (eq[i]) chk("wr_data", {24'h0, eq[i]}, {24'h0, wq[i]});
    $display("masked write test done");
    col = 14'h0400 | 14'($urandom() & 32'h3FF);
    nrd = 0;
    cmd(dram_pkg::CMD_RD, b, col);
    chk("rd_beats", 32'h8, nrd);
    for (int k = 0; k < 8; k++) e[8*k +: 8] = rd_mem[3'(col[2:0] + k)];
    rd(dram_pkg::REG_RDATA0, v);
    rd(dram_pkg::REG_RDATA1, w1);
    chk("rdata_lo", e[31:0], v);
    chk("rdata_hi", e[63:32], w1);
    chk("bank_open", 32'h0, {24'h0, bank_open_q});
    $display("read test done");
    wr(dram_pkg::REG_CTRL, 32'hD);
    cmd(dram_pkg::CMD_MRS, 3'h0, 14'h0001);
    for (int c = 0; c < 2; c++) begin
      col = 14'($urandom() & 32'h3FF) | (c[0] ? 14'h1000 : 14'h0);
      nrd = 0;
      cmd(dram_pkg::CMD_RD, b, col);
      chk("chop_beats", c[0] ? 32'h8 : 32'h4, nrd);
    end
    $display("burst chop test done");
    cmd(dram_pkg::CMD_ACT, b, 14'h0);
    cmd(dram_pkg::CMD_ACT, b ^ 3'h1, 14'h0);
    cmd(dram_pkg::CMD_PRE, b, 14'h0);
    chk("bank_open", 32'h1 << (b ^ 3'h1), {24'h0, bank_open_q});
    pwr(32'hC, dram_pkg::PWR_PD_ACT);
    pwr(32'hD, dram_pkg::PWR_NORMAL);
    cmd(dram_pkg::CMD_PRE, b, 14'h0400);
    chk("bank_open", 32'h0, {24'h0, bank_open_q});
    pwr(32'hC, dram_pkg::PWR_PD_PRE);
    pwr(32'hF, dram_pkg::PWR_NORMAL);
    // A write while the enable is low must leave the control register untouched.
    ce <= 1'b0;
    wr(dram_pkg::REG_CTRL, 32'hC);
    ce <= 1'b1;
    rd(dram_pkg::REG_CTRL, v);
    chk("ce_freeze", 32'hF, v);
    $display("precharge and power-down test done");
    cmd(dram_pkg::CMD_MRS, 3'h1, 14'h0004);
    chk("term_dq", 32'h1, {31'h0, term_dq_q});
    chk("term_tdqs", 32'h0, {31'h0, term_tdqs_q});
    cmd(dram_pkg::CMD_MRS, 3'h1, 14'h0804);
    chk("term_tdqs", 32'h1, {31'h0, term_tdqs_q});
    cmd(dram_pkg::CMD_MRS, 3'h1, 14'h0000);
    chk("term_dq", 32'h0, {31'h0, term_dq_q});
    $display("termination test done");
    // Self-refresh entry needs the gate high before the refresh and low with it, so the two writes abut.
    cmd(dram_pkg::CMD_MRS, 3'h1, 14'h0004);
    @(posedge clk);
    reg_addr  <= dram_pkg::REG_CTRL;
    reg_wdata <= 32'hE;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_addr  <= dram_pkg::REG_CMD;
    reg_wdata <= {29'h0, dram_pkg::CMD_REF};
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (5) @(posedge clk);
    chk("power", {30'h0, dram_pkg::PWR_SELF}, {30'h0, power_state_q});
    chk("term_dq", 32'h0, {31'h0, term_dq_q});
    pwr(32'hF, dram_pkg::PWR_NORMAL);
    $display("self-refresh test done");
    cmd(dram_pkg::CMD_ACT, b, 14'h0);
    wr(dram_pkg::REG_CTRL, 32'hB);
    repeat (3) @(posedge clk);
    chk("bank_open", 32'h0, {24'h0, bank_open_q});
    chk("evt_cmd", {29'h0, dram_pkg::CMD_NOP}, {29'h0, evt_cmd_q});
    $display("device reset test done");
    close_out();
  end
endmodule
